/* rtl/mscr_pkg.sv */
// Constants for the motion sensor configuration word block
package mscr_pkg;

    // ****************************************************************
    // Word geometry
    // ****************************************************************
    localparam int CFG_WIDTH = 56;
    localparam int CNT_WIDTH = 6;
    localparam logic [5:0] CFG_LAST_BIT = 6'h37;
    localparam int LVL_LSB = 15;
    localparam int LVL_MSB = 22;
    localparam int TRIG_BIT = 23;
    localparam int STEP_LSB = 24;
    localparam int STEP_MSB = 25;
    localparam int TYPE_LSB = 26;
    localparam int TYPE_MSB = 28;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] LVL_RESET = 8'h1C;
    localparam logic TRIG_RESET = 1'b0;
    localparam logic [1:0] STEP_RESET = 2'h3;
    localparam logic [2:0] TYPE_RESET = 3'h0;
    localparam logic [55:0] CFG_RESET = 56'h00_0000_030E_0000;

    // ****************************************************************
    // Field encodings
    // ****************************************************************
    typedef enum logic [1:0] {
        MSCR_STEP3 = 2'b00,
        MSCR_STEP1 = 2'b01,
        MSCR_STEP_BAD = 2'b10,
        MSCR_STEP2 = 2'b11
    } mscr_step_t;

    typedef enum logic [2:0] {
        MSCR_TYPE_B = 3'b000,
        MSCR_TYPE_C = 3'b001,
        MSCR_TYPE_D = 3'b010,
        MSCR_DIRECT = 3'b011,
        MSCR_TYPE_A = 3'b111
    } mscr_type_t;

    // Threshold scale is eight, a shift by three
    localparam int LVL_SHIFT = 3;
    localparam int SAMPLE_WIDTH = 12;
endpackage

/* rtl/mscr_window_cmp.sv */
// Symmetric window comparator on the selected sample
`timescale 1ns/100ps
module mscr_window_cmp
    import mscr_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Sample and limit
    input wire logic signed [mscr_pkg::SAMPLE_WIDTH-1:0] sample,
    input wire logic [mscr_pkg::SAMPLE_WIDTH-1:0] magnitude,
    // Result
    output logic aboveUpper,
    output logic belowLower
);
    import mscr_pkg::*;

    logic signed [SAMPLE_WIDTH:0] upperLim; // Plus magnitude, one bit wider
    logic signed [SAMPLE_WIDTH:0] lowerLim; // Minus magnitude
    logic signed [SAMPLE_WIDTH:0] sampleExt; // Sign extended sample

    assign upperLim = $signed({1'b0, magnitude});
    assign lowerLim = -upperLim;
    assign sampleExt = {sample[SAMPLE_WIDTH-1], sample};

    // ****************************************************************
    // Registered compare
    // ****************************************************************
    // Compare against both limits every cycle
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            aboveUpper <= 1'b0;
            belowLower <= 1'b0;
        end else begin
            aboveUpper <= sampleExt > upperLim;
            belowLower <= sampleExt < lowerLim;
        end
    end
endmodule

/* rtl/mscr_config_word.sv */
// Configuration word store for a digital motion sensor
`timescale 1ns/100ps
module mscr_config_word
    import mscr_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Serial write path from the bus slave, after address match
    input wire logic frameStart,
    input wire logic bitValid,
    input wire logic bitData,
    input wire logic frameStop,
    // Samples from the converter and from the band-pass filter
    input wire logic signed [mscr_pkg::SAMPLE_WIDTH-1:0] rawSample,
    input wire logic signed [mscr_pkg::SAMPLE_WIDTH-1:0] filteredSample,
    // Decoded configuration
    output logic [7:0] detectThresholdLevel,
    output logic triggerOutputEnable,
    output logic [1:0] filterGainStep,
    output logic [2:0] filterTypeSelect,
    output logic filterBypass,
    output logic [mscr_pkg::SAMPLE_WIDTH-1:0] thresholdMagnitude,
    // Filter restart and detection result
    output logic filterRestart,
    output logic aboveUpper,
    output logic belowLower
);
    import mscr_pkg::*;

    // ****************************************************************
    // Storage
    // ****************************************************************
    logic [CFG_WIDTH-1:0] cfgWord_reg; // Live configuration word
    logic [CFG_WIDTH-1:0] shift_reg; // Incoming bits
    logic [CNT_WIDTH-1:0] bitCount_reg; // Bits taken this frame
    logic full_reg; // All 56 bits received
    logic commit; // Frame done with a whole word
    logic [1:0] newStep; // Step field of the incoming word
    logic [2:0] newType; // Type field of the incoming word
    logic signed [SAMPLE_WIDTH-1:0] pathSample; // Sample fed to compare

    assign newStep = shift_reg[STEP_MSB:STEP_LSB];
    assign newType = shift_reg[TYPE_MSB:TYPE_LSB];
    // A short frame is dropped so a torn write never half-applies
    assign commit = frameStop && full_reg;

    // ****************************************************************
    // Serial capture
    // ****************************************************************
    // First bit after the address is bit 55; no sub-address byte
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            shift_reg <= '0;
            bitCount_reg <= '0;
            full_reg <= 1'b0;
        end else if (frameStart) begin
            bitCount_reg <= '0;
            full_reg <= 1'b0;
        end else if (bitValid && !full_reg) begin
            shift_reg <= {shift_reg[CFG_WIDTH-2:0], bitData};
            bitCount_reg <= bitCount_reg + 6'h01;
            full_reg <= bitCount_reg == CFG_LAST_BIT;
        end else if (frameStop) begin
            full_reg <= 1'b0;
        end
    end

    // ****************************************************************
    // Word update
    // ****************************************************************
    // Reset is the power-up load; a written default word is the soft reset
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cfgWord_reg <= CFG_RESET;
        end else if (commit) begin
            cfgWord_reg <= shift_reg;
        end
    end

    // Restart the filter when step or type really changes
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            filterRestart <= 1'b1;
        end else begin
            filterRestart <= commit && ((newStep != cfgWord_reg[STEP_MSB:STEP_LSB]) ||
                (newType != cfgWord_reg[TYPE_MSB:TYPE_LSB]));
        end
    end

    // ****************************************************************
    // Field decode
    // ****************************************************************
    // Stored bits stay as written; undefined codes decode as defaults
    always_comb begin
        detectThresholdLevel = cfgWord_reg[LVL_MSB:LVL_LSB];
        triggerOutputEnable = cfgWord_reg[TRIG_BIT];
        filterGainStep = cfgWord_reg[STEP_MSB:STEP_LSB];
        if (filterGainStep == MSCR_STEP_BAD) begin
            filterGainStep = STEP_RESET;
        end
        case (cfgWord_reg[TYPE_MSB:TYPE_LSB])
            MSCR_TYPE_A, MSCR_TYPE_B, MSCR_TYPE_C, MSCR_TYPE_D, MSCR_DIRECT: begin
                filterTypeSelect = cfgWord_reg[TYPE_MSB:TYPE_LSB];
            end
            default: begin
                filterTypeSelect = TYPE_RESET;
            end
        endcase
        filterBypass = filterTypeSelect == MSCR_DIRECT;
        // Level 255 gives 2040, which still fits a 12-bit magnitude
        thresholdMagnitude = {1'b0, detectThresholdLevel, 3'h0};
    end

    // Direct mode routes the raw sample past the filter
    assign pathSample = filterBypass ? rawSample : filteredSample;

    // ****************************************************************
    // Window comparator
    // ****************************************************************
    mscr_window_cmp uCmp (
        .clock(clock),
        .sys_rst(sys_rst),
        .sample(pathSample),
        .magnitude(thresholdMagnitude),
        .aboveUpper(aboveUpper),
        .belowLower(belowLower)
    );

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence s_commitWord;
        commit;
    endsequence

    property p_rstDefault;
        @(posedge clock) sys_rst |=> cfgWord_reg == CFG_RESET;
    endproperty
    a_rstDefault: assert property (p_rstDefault) else $error("reset word wrong");

    property p_commitLoad;
        @(posedge clock) disable iff (sys_rst)
            s_commitWord |=> cfgWord_reg == $past(shift_reg);
    endproperty
    a_commitLoad: assert property (p_commitLoad) else $error("word not loaded");

    property p_holdNoCommit;
        @(posedge clock) disable iff (sys_rst) !commit |=> $stable(cfgWord_reg);
    endproperty
    a_holdNoCommit: assert property (p_holdNoCommit) else $error("word changed");

    property p_trigReset;
        @(posedge clock) sys_rst |=> !triggerOutputEnable;
    endproperty
    a_trigReset: assert property (p_trigReset) else $error("trigger not off");

    property p_magnitude;
        @(posedge clock) disable iff (sys_rst)
            thresholdMagnitude == 12'(int'(detectThresholdLevel) * 8);
    endproperty
    a_magnitude: assert property (p_magnitude) else $error("magnitude wrong");

    property p_bypass;
        @(posedge clock) disable iff (sys_rst)
            cfgWord_reg[TYPE_MSB:TYPE_LSB] == 3'h3 |-> filterBypass && pathSample == rawSample;
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass not taken");

    property p_badStep;
        @(posedge clock) disable iff (sys_rst)
            cfgWord_reg[STEP_MSB:STEP_LSB] == 2'h2 |-> filterGainStep == 2'h3;
    endproperty
    a_badStep: assert property (p_badStep) else $error("bad step leaked");

    property p_restart;
        @(posedge clock) disable iff (sys_rst)
            s_commitWord ##0 (newType != cfgWord_reg[TYPE_MSB:TYPE_LSB]) |=> filterRestart;
    endproperty
    a_restart: assert property (p_restart) else $error("no restart");

    property p_window;
        @(posedge clock) disable iff (sys_rst)
            (int'(pathSample) > int'(thresholdMagnitude)) |=> aboveUpper;
    endproperty
    a_window: assert property (p_window) else $error("upper miss");

    property p_windowLow;
        @(posedge clock) disable iff (sys_rst)
            (int'(pathSample) < -int'(thresholdMagnitude)) |=> belowLower;
    endproperty
    a_windowLow: assert property (p_windowLow) else $error("lower miss");

    property p_msbFirst;
        @(posedge clock) disable iff (sys_rst)
            bitValid && !full_reg && !frameStart |=> shift_reg[0] == $past(bitData);
    endproperty
    a_msbFirst: assert property (p_msbFirst) else $error("shift order");
endmodule

/* test/mscr_host_model.sv */
// Host model that shifts the configuration word into the device
`timescale 1ns/100ps
module mscr_host_model
(
    // Clock
    input wire logic clock,
    // Serial write path toward the device
    output logic frameStart,
    output logic bitValid,
    output logic bitData,
    output logic frameStop
);
    // ****************************************************************
    // Frame driver
    // ****************************************************************
    // All lines idle at time zero
    initial begin
        frameStart = 1'b0;
        bitValid = 1'b0;
        bitData = 1'b0;
        frameStop = 1'b0;
    end

    // One write frame; a gap makes a slow host, data toggles when not valid
    task automatic send_frame(input logic [55:0] w, input int nBits, input int gap);
        int i;
        int g;
        @(posedge clock);
        frameStart <= 1'b1;
        for (i = 0; i < nBits; i++) begin
            @(posedge clock);
            frameStart <= 1'b0;
            bitValid <= 1'b1;
            bitData <= w[55-i];
            for (g = 0; g < gap; g++) begin
                @(posedge clock);
                bitValid <= 1'b0;
                bitData <= ~bitData;
            end
        end
        @(posedge clock);
        frameStart <= 1'b0;
        bitValid <= 1'b0;
        bitData <= ~bitData;
        frameStop <= 1'b1;
        @(posedge clock);
        frameStop <= 1'b0;
    endtask
endmodule

/* test/tb.sv */
// Self-checking bench for the configuration word block
`timescale 1ns/100ps
module tb;
    import mscr_pkg::*;
    // ****************************************************************
    // Signals
    // ****************************************************************
    logic clock;
    logic sys_rst;
    logic frameStart, bitValid, bitData, frameStop;
    logic signed [SAMPLE_WIDTH-1:0] rawSample, filteredSample;
    logic [7:0] detectThresholdLevel;
    logic triggerOutputEnable, filterBypass, filterRestart, aboveUpper, belowLower;
    logic [1:0] filterGainStep;
    logic [2:0] filterTypeSelect;
    logic [SAMPLE_WIDTH-1:0] thresholdMagnitude;
    int bad_count, samples_checked, restartSeen, k;
    logic [10:0] m; // Current mode table entry
    // Mode table: byp, expType, expStep, type, step
    logic [10:0] modeTab [7] = '{11'h063, 11'h084, 11'h16A, 11'h5AD, 11'h073, 11'h014, 11'h039};

    mscr_host_model host (.clock(clock), .frameStart(frameStart), .bitValid(bitValid),
        .bitData(bitData), .frameStop(frameStop));
    mscr_config_word dut (.clock(clock), .sys_rst(sys_rst), .frameStart(frameStart),
        .bitValid(bitValid), .bitData(bitData), .frameStop(frameStop), .rawSample(rawSample),
        .filteredSample(filteredSample), .detectThresholdLevel(detectThresholdLevel),
        .triggerOutputEnable(triggerOutputEnable), .filterGainStep(filterGainStep),
        .filterTypeSelect(filterTypeSelect), .filterBypass(filterBypass),
        .thresholdMagnitude(thresholdMagnitude), .filterRestart(filterRestart),
        .aboveUpper(aboveUpper), .belowLower(belowLower));

    // ****************************************************************
    // Clock, restart monitor, watchdog
    // ****************************************************************
    // 200 MHz clock
    initial clock = 1'b0;
    always #2.5 clock = ~clock;
    // Counts restart pulses outside reset
    always @(posedge clock) begin
        if (sys_rst === 1'b0 && filterRestart === 1'b1) begin
            restartSeen <= restartSeen + 1;
        end
    end
    // Cuts a hang short
    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        close_out();
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    // Reserved positions always zero from this host
    function automatic logic [55:0] mk_word(logic [7:0] l, logic t, logic [1:0] s, logic [2:0] y);
        return {27'h0, y, s, t, l, 15'h0};
    endfunction
    // Single compare for every result
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Write a frame and count restart pulses it caused
    task automatic write_cfg(input logic [55:0] w, input int n, input int gap, input logic rs);
        int r0;
        r0 = restartSeen;
        host.send_frame(w, n, gap);
        // Short settle before trusting any output, scaled down here
        repeat (4) @(posedge clock);
        @(negedge clock);
        chk(12'(restartSeen - r0), {11'h0, rs});
    endtask
    // Decoded field check
    task automatic check_cfg(logic [7:0] l, logic t, logic [1:0] s, logic [2:0] y, logic b);
        chk({4'h0, detectThresholdLevel}, {4'h0, l});
        chk({11'h0, triggerOutputEnable}, {11'h0, t});
        chk({10'h0, filterGainStep}, {10'h0, s});
        chk({9'h0, filterTypeSelect}, {9'h0, y});
        chk({11'h0, filterBypass}, {11'h0, b});
        chk(thresholdMagnitude, {1'b0, l, 3'h0});
    endtask
    // Drive one sample pair and look at the flags a cycle later
    task automatic probe(input logic [11:0] r, input logic [11:0] f, input logic a, input logic b);
        @(posedge clock);
        rawSample <= r;
        filteredSample <= f;
        @(posedge clock);
        @(negedge clock);
        chk({10'h0, aboveUpper, belowLower}, {10'h0, a, b});
    endtask
    // Verdict and end of run
    task automatic close_out();
        if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        sys_rst = 1'b1;
        rawSample = 12'h000;
        filteredSample = 12'h000;
        repeat (16) @(posedge clock);
        @(negedge clock);
        chk({11'h0, filterRestart}, 12'h001);
        @(posedge clock);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clock);
        @(negedge clock);
        check_cfg(8'h1C, 1'b0, 2'h3, 3'h0, 1'b0);
        // Full word, then same word slowly: no second restart
        write_cfg(mk_word(8'hFF, 1'b1, 2'h1, 3'h7), 56, 0, 1'b1);
        check_cfg(8'hFF, 1'b1, 2'h1, 3'h7, 1'b0);
        write_cfg(mk_word(8'hFF, 1'b1, 2'h1, 3'h7), 56, 2, 1'b0);
        // A frame one bit short is dropped
        write_cfg(mk_word(8'h10, 1'b0, 2'h3, 3'h0), 55, 0, 1'b0);
        check_cfg(8'hFF, 1'b1, 2'h1, 3'h7, 1'b0);
        // Every step code and type codes 0 to 6, undefined ones included
        for (k = 0; k < 7; k++) begin
            m = modeTab[k];
            write_cfg(mk_word(8'h10, 1'b0, m[1:0], m[4:2]), 56, 0, 1'b1);
            check_cfg(8'h10, 1'b0, m[6:5], m[9:7], m[10]);
        end
        // Window of plus and minus 128 on the filtered path
        probe(12'h000, 12'h081, 1'b1, 1'b0);
        probe(12'h000, 12'hF7F, 1'b0, 1'b1);
        probe(12'h081, 12'h080, 1'b0, 1'b0);
        probe(12'hF7F, 12'hF80, 1'b0, 1'b0);
        // Direct mode takes the raw sample
        write_cfg(mk_word(8'h10, 1'b0, 2'h1, 3'h3), 56, 0, 1'b1);
        probe(12'h081, 12'h000, 1'b1, 1'b0);
        probe(12'h000, 12'hF7F, 1'b0, 1'b0);
        // Writing the defaults restores reset behaviour
        write_cfg(mk_word(8'h1C, 1'b0, 2'h3, 3'h0), 56, 0, 1'b1);
        check_cfg(8'h1C, 1'b0, 2'h3, 3'h0, 1'b0);
        // Second reset in mid-run reloads defaults
        write_cfg(mk_word(8'h55, 1'b1, 2'h0, 3'h2), 56, 0, 1'b1);
        @(posedge clock);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clock);
        @(negedge clock);
        check_cfg(8'h1C, 1'b0, 2'h3, 3'h0, 1'b0);
        close_out();
    end
endmodule
